// [design/fbpk_cfg.svh]
`ifndef FBPK_CFG_SVH
`define FBPK_CFG_SVH

// luma weights, sum 256
`define FBPK_LUMA_R 18'h0004d
`define FBPK_LUMA_G 18'h00096
`define FBPK_LUMA_B 18'h0001d
`define FBPK_LUMA_SHIFT 8

// grayscale divisors and expansion multipliers
`define FBPK_GRAY4_DIV 8'h11
`define FBPK_GRAY2_DIV 8'h55
`define FBPK_GRAY1_DIV 8'hff
`define FBPK_GRAY4_MUL 32'h00111111
`define FBPK_GRAY2_MUL 32'h00555555
`define FBPK_GRAY1_MUL 32'h00ffffff
`define FBPK_OPAQUE 32'hff000000
`define FBPK_ALPHA_FULL 8'hff

// reset values
`define FBPK_RST_WORD 32'h00000000
`define FBPK_RST_BIT 1'b0

`endif

// [design/fbpk_pkg.sv]
package fbpk_pkg;

  typedef enum logic [2:0] {
    fmt_argb8888 = 3'h0,
    fmt_rgb888 = 3'h1,
    fmt_rgb565 = 3'h2,
    fmt_argb1555 = 3'h3,
    fmt_argb4444 = 3'h4,
    gray_four_bit_format = 3'h5,
    gray_two_bit_format = 3'h6,
    gray_one_bit_format = 3'h7
  } fbpk_fmt_e;

  typedef enum logic {
    pack_line = 1'b0,
    pack_column = 1'b1
  } fbpk_pack_e;

  typedef enum logic {
    scan_row = 1'b0,
    scan_column = 1'b1
  } fbpk_scan_e;

  typedef enum logic {
    op_pack = 1'b0,
    op_unpack = 1'b1
  } fbpk_op_e;

  typedef logic [11:0] fbpk_coord_t;

  // static frame configuration
  typedef struct packed {
    fbpk_fmt_e fmt;
    fbpk_pack_e pixel_packing_order;
    fbpk_scan_e frame_scan_order;
    fbpk_coord_t width;
    fbpk_coord_t height;
    logic [31:0] base;
  } fbpk_cfg_s;

  // one pixel request from the drawing engine
  typedef struct packed {
    fbpk_op_e op;
    fbpk_coord_t x;
    fbpk_coord_t y;
    logic [31:0] data;
  } fbpk_req_s;

  // one memory access description toward the frame buffer
  typedef struct packed {
    fbpk_op_e op;
    logic [31:0] addr;
    logic [2:0] nbytes;
    logic [2:0] bit_pos;
    logic [7:0] bit_mask;
    logic [31:0] data;
  } fbpk_rsp_s;

endpackage

// [design/fbpk_buf.sv]
`timescale 1ns/1ns
// two-entry buffer: output stage plus skid stage, all outputs from flops
module fbpk_buf #(
  parameter int W = 8
) (
  // clock and synchronised reset
  input wire logic core_clk,
  input wire logic rst_sync_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic skid_valid_r;
  logic [W-1:0] skid_data_r;
  logic push;
  logic out_free;

  assign push = in_valid & in_ready;
  assign out_free = ~out_valid | out_ready;

  // occupancy of both stages
  always_ff @(posedge core_clk) begin
    if (!rst_sync_n) begin
      out_valid <= 1'b0;
      skid_valid_r <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      if (out_free) begin
        out_valid <= skid_valid_r | push;
        skid_valid_r <= 1'b0;
        in_ready <= 1'b1;
      end else if (push) begin
        skid_valid_r <= 1'b1;
        in_ready <= 1'b0; // stall source while both full
      end
    end
  end

  // data movement
  always_ff @(posedge core_clk) begin
    if (!rst_sync_n) begin
      out_data <= '0;
      skid_data_r <= '0;
    end else begin
      if (out_free) begin
        if (skid_valid_r) begin
          out_data <= skid_data_r;
        end else if (push) begin
          out_data <= in_data;
        end
      end else if (push) begin
        skid_data_r <= in_data;
      end
    end
  end

endmodule

// [design/fbpk_top.sv]
`timescale 1ns/1ns
`include "fbpk_cfg.svh"
// pixel packer: address, bit slot and colour conversion per pixel
module fbpk_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // frame configuration, held stable while requests flow
  input wire fbpk_pkg::fbpk_cfg_s cfg,
  // request stream from the drawing engine
  input wire logic req_valid,
  output logic req_ready,
  input wire fbpk_pkg::fbpk_req_s req,
  // access stream toward frame buffer memory
  output logic rsp_valid,
  input wire logic rsp_ready,
  output fbpk_pkg::fbpk_rsp_s rsp
);

  logic rst_meta_r;
  logic rst_sync_n_r;
  fbpk_pkg::fbpk_rsp_s calc;

  // reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= `FBPK_RST_BIT;
      rst_sync_n_r <= `FBPK_RST_BIT;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // bits per pixel of each format
  function automatic logic [5:0] bpp_of(input fbpk_pkg::fbpk_fmt_e f);
    logic [5:0] b;
    b = 6'h00;
    unique case (f)
      fbpk_pkg::fmt_argb8888: b = 6'h20;
      fbpk_pkg::fmt_rgb888: b = 6'h18;
      fbpk_pkg::fmt_rgb565: b = 6'h10;
      fbpk_pkg::fmt_argb1555: b = 6'h10;
      fbpk_pkg::fmt_argb4444: b = 6'h10;
      fbpk_pkg::gray_four_bit_format: b = 6'h04;
      fbpk_pkg::gray_two_bit_format: b = 6'h02;
      fbpk_pkg::gray_one_bit_format: b = 6'h01;
    endcase
    return b;
  endfunction

  // log2 of pixels per byte, zero for whole-byte formats
  function automatic logic [1:0] lg_ppb(input fbpk_pkg::fbpk_fmt_e f);
    logic [1:0] l;
    l = 2'h0;
    unique case (f)
      fbpk_pkg::gray_four_bit_format: l = 2'h1;
      fbpk_pkg::gray_two_bit_format: l = 2'h2;
      fbpk_pkg::gray_one_bit_format: l = 2'h3;
      default: l = 2'h0;
    endcase
    return l;
  endfunction

  // widen a 5-bit field by copying its top bits
  function automatic logic [7:0] rep5(input logic [4:0] v);
    return {v, v[4:2]};
  endfunction

  // widen a 6-bit field by copying its top bits
  function automatic logic [7:0] rep6(input logic [5:0] v);
    return {v, v[5:4]};
  endfunction

  // narrow a component to its top four bits
  function automatic logic [3:0] top4(input logic [7:0] v);
    return v[7:4];
  endfunction

  // narrow a component to its top five bits
  function automatic logic [4:0] top5(input logic [7:0] v);
    return v[7:3];
  endfunction

  // narrow a component to its top six bits
  function automatic logic [5:0] top6(input logic [7:0] v);
    return v[7:2];
  endfunction

  // ones in the low n bits of a byte
  function automatic logic [7:0] low_mask(input logic [2:0] n);
    return 8'((9'h001 << n) - 9'h001);
  endfunction

  // slot of a pixel inside its byte group
  function automatic logic [2:0] slot_of(input logic [31:0] v, input logic [2:0] m);
    return v[2:0] & m;
  endfunction

  // whole-byte pixels: row after row, bpp/8 bytes each
  function automatic logic [31:0] off_wide(input logic [31:0] x, input logic [31:0] y,
                                           input logic [31:0] w, input logic [2:0] nb);
    logic [31:0] idx;
    idx = y * w + x;
    return idx * {29'h0, nb};
  endfunction

  // row scan, line packing: padded run of bytes per row
  function automatic logic [31:0] off_row_line(input logic [31:0] x, input logic [31:0] y,
                                               input logic [31:0] runs, input logic [1:0] l);
    return y * runs + (x >> l);
  endfunction

  // row scan, column packing: one byte per column in a band of rows
  function automatic logic [31:0] off_row_col(input logic [31:0] x, input logic [31:0] y,
                                              input logic [31:0] w, input logic [1:0] l);
    return (y >> l) * w + x;
  endfunction

  // column scan, line packing: one byte per row in a band of columns
  function automatic logic [31:0] off_col_line(input logic [31:0] x, input logic [31:0] y,
                                               input logic [31:0] h, input logic [1:0] l);
    return (x >> l) * h + y;
  endfunction

  // column scan, column packing: padded run of bytes per column
  function automatic logic [31:0] off_col_col(input logic [31:0] x, input logic [31:0] y,
                                              input logic [31:0] runs, input logic [1:0] l);
    return x * runs + (y >> l);
  endfunction

  // weighted luma, clamped to one byte
  function automatic logic [7:0] gray_of(input logic [31:0] c);
    logic [17:0] s;
    s = `FBPK_LUMA_R * {10'h000, c[23:16]}
      + `FBPK_LUMA_G * {10'h000, c[15:8]}
      + `FBPK_LUMA_B * {10'h000, c[7:0]};
    if (s[17:16] != 2'h0) begin
      return 8'hff;
    end
    return s[15:8];
  endfunction

  // argb colour to stored pixel, built-in path only
  function automatic logic [31:0] to_pixel(input fbpk_pkg::fbpk_fmt_e f,
                                           input logic [31:0] c);
    logic [31:0] p;
    logic [7:0] g;
    logic [7:0] q;
    p = `FBPK_RST_WORD;
    g = gray_of(c);
    q = 8'h00;
    unique case (f)
      fbpk_pkg::fmt_argb8888: p = c;
      fbpk_pkg::fmt_rgb888: p = {8'h00, c[23:0]};
      fbpk_pkg::fmt_rgb565:
        p = {16'h0000, top5(c[23:16]), top6(c[15:8]), top5(c[7:0])};
      fbpk_pkg::fmt_argb1555:
        p = {16'h0000, c[31], top5(c[23:16]), top5(c[15:8]), top5(c[7:0])};
      fbpk_pkg::fmt_argb4444:
        p = {16'h0000, top4(c[31:24]), top4(c[23:16]), top4(c[15:8]), top4(c[7:0])};
      fbpk_pkg::gray_four_bit_format: begin
        q = g / `FBPK_GRAY4_DIV;
        p = {28'h0000000, q[3:0]};
      end
      fbpk_pkg::gray_two_bit_format: begin
        q = g / `FBPK_GRAY2_DIV;
        p = {30'h00000000, q[1:0]};
      end
      fbpk_pkg::gray_one_bit_format: begin
        q = g / `FBPK_GRAY1_DIV;
        p = {31'h00000000, q[0]};
      end
    endcase
    return p;
  endfunction

  // stored pixel back to argb colour
  function automatic logic [31:0] from_pixel(input fbpk_pkg::fbpk_fmt_e f,
                                             input logic [31:0] p);
    logic [31:0] c;
    c = `FBPK_RST_WORD;
    unique case (f)
      fbpk_pkg::fmt_argb8888: c = p;
      fbpk_pkg::fmt_rgb888: c = {`FBPK_ALPHA_FULL, p[23:0]};
      fbpk_pkg::fmt_rgb565:
        c = {`FBPK_ALPHA_FULL, rep5(p[15:11]), rep6(p[10:5]), rep5(p[4:0])};
      fbpk_pkg::fmt_argb1555:
        c = {{8{p[15]}}, rep5(p[14:10]), rep5(p[9:5]), rep5(p[4:0])};
      fbpk_pkg::fmt_argb4444:
        c = {{2{p[15:12]}}, {2{p[11:8]}}, {2{p[7:4]}}, {2{p[3:0]}}};
      fbpk_pkg::gray_four_bit_format:
        c = `FBPK_OPAQUE | ({28'h0000000, p[3:0]} * `FBPK_GRAY4_MUL);
      fbpk_pkg::gray_two_bit_format:
        c = `FBPK_OPAQUE | ({30'h00000000, p[1:0]} * `FBPK_GRAY2_MUL);
      fbpk_pkg::gray_one_bit_format:
        c = `FBPK_OPAQUE | ({31'h00000000, p[0]} * `FBPK_GRAY1_MUL);
    endcase
    return c;
  endfunction

  // address and slot arithmetic
  logic [5:0] bpp;
  logic [1:0] lg;
  logic [2:0] gmask;
  logic [31:0] xw;
  logic [31:0] yw;
  logic [31:0] wd;
  logic [31:0] ht;
  logic [31:0] per_row;
  logic [31:0] per_col;
  logic [31:0] offs;
  logic [2:0] slot;
  logic [2:0] pos;
  logic [7:0] fmask;
  logic [31:0] pix;
  logic [7:0] rawv;

  // frame geometry in 32-bit form
  always_comb begin
    bpp = bpp_of(cfg.fmt);
    lg = lg_ppb(cfg.fmt);
    gmask = 3'(low_mask({1'b0, lg}));
    xw = {20'h00000, req.x};
    yw = {20'h00000, req.y};
    wd = {20'h00000, cfg.width};
    ht = {20'h00000, cfg.height};
    per_row = (wd + {29'h0, gmask}) >> lg;
    per_col = (ht + {29'h0, gmask}) >> lg;
  end

  // byte offset and bit slot of the requested pixel
  always_comb begin
    offs = `FBPK_RST_WORD;
    slot = 3'h0;
    if (lg == 2'h0) begin
      offs = off_wide(xw, yw, wd, bpp[5:3]);
    end else begin
      unique case ({cfg.frame_scan_order, cfg.pixel_packing_order})
        {fbpk_pkg::scan_row, fbpk_pkg::pack_line}: begin
          offs = off_row_line(xw, yw, per_row, lg);
          slot = slot_of(xw, gmask);
        end
        {fbpk_pkg::scan_row, fbpk_pkg::pack_column}: begin
          offs = off_row_col(xw, yw, wd, lg);
          slot = slot_of(yw, gmask);
        end
        {fbpk_pkg::scan_column, fbpk_pkg::pack_line}: begin
          offs = off_col_line(xw, yw, ht, lg);
          slot = slot_of(xw, gmask);
        end
        {fbpk_pkg::scan_column, fbpk_pkg::pack_column}: begin
          offs = off_col_col(xw, yw, per_col, lg);
          slot = slot_of(yw, gmask);
        end
      endcase
    end
    pos = 3'(slot * bpp[2:0]);
    fmask = low_mask(bpp[2:0]);
  end

  // built-in colour conversion and raw slot value
  always_comb begin
    pix = to_pixel(cfg.fmt, req.data);
    rawv = (req.data[7:0] >> pos) & fmask;
  end

  // placement of the pixel bits in the access
  always_comb begin
    calc.op = req.op;
    calc.addr = cfg.base + offs;
    calc.bit_pos = pos;
    if (lg == 2'h0) begin
      calc.nbytes = bpp[5:3];
      calc.bit_mask = 8'hff;
      if (req.op == fbpk_pkg::op_pack) begin
        calc.data = pix;
      end else begin
        calc.data = from_pixel(cfg.fmt, req.data);
      end
    end else begin
      calc.nbytes = 3'h1;
      calc.bit_mask = 8'(fmask << pos);
      if (req.op == fbpk_pkg::op_pack) begin
        calc.data = {24'h000000, 8'(pix[7:0] << pos)};
      end else begin
        calc.data = from_pixel(cfg.fmt, {24'h000000, rawv});
      end
    end
  end

  // two-entry buffer toward memory; its ready stalls the drawing engine
  fbpk_buf #(
    .W($bits(fbpk_pkg::fbpk_rsp_s))
  ) u_buf (
    .core_clk(core_clk),
    .rst_sync_n(rst_sync_n_r),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(calc),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp)
  );

endmodule

// [testbench/fbpk_checker.sv]
`timescale 1ns/1ns
// port-level checks on the packer
module fbpk_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // configuration and streams
  input wire fbpk_pkg::fbpk_cfg_s cfg,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire fbpk_pkg::fbpk_req_s req,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire fbpk_pkg::fbpk_rsp_s rsp
);
  logic sub;
  logic direct;
  logic [7:0] pmask;
  // sub-byte format and its pixel mask
  assign sub = cfg.fmt >= fbpk_pkg::gray_four_bit_format;
  assign pmask = (cfg.fmt == fbpk_pkg::gray_four_bit_format) ? 8'h0f :
    (cfg.fmt == fbpk_pkg::gray_two_bit_format) ? 8'h03 : 8'h01;
  // request that goes straight to the output stage
  assign direct = req_valid && req_ready && (!rsp_valid || rsp_ready);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_stall_holds: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("response changed while stalled");
  a_full_blocks: assert property (!req_ready && rsp_valid && !rsp_ready |=> !req_ready)
    else $error("ready rose while full");
  a_wide_bytes: assert property (rsp_valid && !sub |-> rsp.nbytes ==
    ((cfg.fmt == fbpk_pkg::fmt_argb8888) ? 3'h4 : (cfg.fmt == fbpk_pkg::fmt_rgb888) ? 3'h3 : 3'h2))
    else $error("wrong byte count");
  a_wide_whole: assert property (rsp_valid && !sub |-> rsp.bit_mask == 8'hff && rsp.bit_pos == 3'h0)
    else $error("wide pixel not whole bytes");
  a_sub_byte: assert property (rsp_valid && sub |-> rsp.nbytes == 3'h1)
    else $error("sub-byte pixel spans bytes");
  a_sub_slot: assert property (rsp_valid && sub |-> rsp.bit_mask == 8'(pmask << rsp.bit_pos) && rsp.bit_mask != 8'h00)
    else $error("bit mask off slot");
  a_pack_clean: assert property (rsp_valid && sub && rsp.op == fbpk_pkg::op_pack |-> (rsp.data[7:0] & ~rsp.bit_mask) == 8'h00)
    else $error("packed bits outside slot");
  a_argb_same: assert property (direct && cfg.fmt == fbpk_pkg::fmt_argb8888 |=> rsp.data == $past(req.data))
    else $error("argb value altered");
  a_gray4_expand: assert property (direct && req.op == fbpk_pkg::op_unpack && cfg.fmt == fbpk_pkg::gray_four_bit_format |=>
    rsp.data == (32'hff000000 | ((($past(req.data) >> rsp.bit_pos) & 32'hf) * 32'h00111111)))
    else $error("gray4 expansion wrong");
endmodule

bind fbpk_top fbpk_checker fbpk_checker_inst (.core_clk(core_clk), .rst_n(rst_n), .cfg(cfg),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
  .rsp_ready(rsp_ready), .rsp(rsp));

// [testbench/fbpk_mem_model.sv]
`timescale 1ns/1ns
// frame buffer side: takes accesses, may stall
module fbpk_mem_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // stall controls
  input wire logic stall,
  input wire logic slow,
  // access stream
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire fbpk_pkg::fbpk_rsp_s rsp,
  // last accepted access
  output logic got,
  output fbpk_pkg::fbpk_rsp_s seen
);
  // ready follows stall; slow accepts every other cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_ready <= 1'b0;
    end else begin
      rsp_ready <= !stall && (!slow || !rsp_ready);
    end
  end
  // capture each accepted access
  always_ff @(posedge core_clk) begin
    got <= rsp_valid && rsp_ready;
    if (rsp_valid && rsp_ready) begin
      seen <= rsp;
    end
  end
endmodule

// [testbench/fbpk_top_tb.sv]
`timescale 1ns/1ns
module fbpk_top_tb;
  logic core_clk, rst_n, req_valid, req_ready, rsp_valid, rsp_ready, stall, slow, got;
  fbpk_pkg::fbpk_cfg_s cfg;
  fbpk_pkg::fbpk_req_s req;
  fbpk_pkg::fbpk_rsp_s rsp, seen;
  int miscompares, n_compared;

  fbpk_top fbpk_top_inst (.core_clk(core_clk), .rst_n(rst_n), .cfg(cfg), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp));
  fbpk_mem_model fbpk_mem_model_inst (.core_clk(core_clk), .rst_n(rst_n), .stall(stall),
    .slow(slow), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .got(got), .seen(seen));

  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [31:0] sv, input logic [31:0] ev);
    n_compared++;
    if (sv !== ev) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, ev, sv);
    end
  endtask

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // wait for the next access taken by the far side
  task automatic catch;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (got !== 1'b1 && n < 100);
    if (got !== 1'b1) begin
      miscompares++;
      conclude;
    end
  endtask

  task automatic xfer(input fbpk_pkg::fbpk_op_e op, input int x, input int y, input logic [31:0] d);
    req_valid <= 1'b1;
    req <= '{op, 12'(x), 12'(y), d};
    do @(posedge core_clk); while (!req_ready);
    req_valid <= 1'b0;
    catch;
  endtask

  // wide formats: address and conversion
  task automatic t_wide;
    logic [31:0] c, e;
    c = 32'h9ac3e75b;
    for (int f = 0; f < 5; f++) begin
      cfg.fmt <= fbpk_pkg::fbpk_fmt_e'(f);
      case (f)
        0: e = c;
        1: e = 32'h00c3e75b;
        2: e = 32'h0000c72b;
        3: e = 32'h0000e38b;
        default: e = 32'h00009ce5;
      endcase
      xfer(fbpk_pkg::op_pack, 1, 2, c);
      chk("wide addr", seen.addr, 32'h100 + 21 * (f == 0 ? 4 : f == 1 ? 3 : 2));
      chk("wide bytes", seen.nbytes, f == 0 ? 4 : f == 1 ? 3 : 2);
      chk("wide pack", seen.data, e);
    end
    xfer(fbpk_pkg::op_unpack, 0, 0, 32'h00001234);
    chk("4444 unpack", seen.data, 32'h11223344);
    cfg.fmt <= fbpk_pkg::fmt_argb8888;
    xfer(fbpk_pkg::op_unpack, 0, 0, c);
    chk("argb unpack", seen.data, c);
    chk("unpack op", seen.op, fbpk_pkg::op_unpack);
  endtask

  // sub-byte formats over every order combination
  task automatic t_sub;
    int bpp, ppb, off, slot, v;
    for (int f = 5; f < 8; f++) begin
      for (int m = 0; m < 4; m++) begin
        bpp = (f == 5) ? 4 : (f == 6) ? 2 : 1;
        ppb = 8 / bpp;
        cfg.fmt <= fbpk_pkg::fbpk_fmt_e'(f);
        cfg.pixel_packing_order <= fbpk_pkg::fbpk_pack_e'(m[0]);
        cfg.frame_scan_order <= fbpk_pkg::fbpk_scan_e'(m[1]);
        case (m)
          0: off = 3 * ((10 + ppb - 1) / ppb) + 5 / ppb;
          1: off = (3 / ppb) * 10 + 5;
          2: off = (5 / ppb) * 6 + 3;
          default: off = 5 * ((6 + ppb - 1) / ppb) + 3 / ppb;
        endcase
        slot = m[0] ? 3 % ppb : 5 % ppb;
        v = (f == 5) ? 9 : (f == 6) ? 1 : 0;
        xfer(fbpk_pkg::op_pack, 5, 3, 32'h00ff8040);
        chk("sub addr", seen.addr, 32'h100 + off);
        chk("sub pos", seen.bit_pos, slot * bpp);
        chk("sub mask", seen.bit_mask, ((1 << bpp) - 1) << (slot * bpp));
        chk("sub pack", seen.data[7:0], v << (slot * bpp));
        xfer(fbpk_pkg::op_unpack, 5, 3, 32'h000000b4);
        v = (8'hb4 >> (slot * bpp)) & ((1 << bpp) - 1);
        chk("sub unpack", seen.data, 32'hff000000 |
          (v * (f == 5 ? 32'h111111 : f == 6 ? 32'h555555 : 32'hffffff)));
      end
    end
  endtask

  // stalled far side: buffer fills, order kept
  task automatic t_stall;
    stall <= 1'b1;
    cfg.fmt <= fbpk_pkg::fmt_rgb565;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 2; i++) begin
      req_valid <= 1'b1;
      req <= '{fbpk_pkg::op_pack, 12'(i), 12'h0, 32'h0};
      do @(posedge core_clk); while (!req_ready);
    end
    req_valid <= 1'b0;
    @(posedge core_clk);
    chk("ready full", req_ready, 0);
    stall <= 1'b0;
    catch;
    chk("first addr", seen.addr, 32'h100);
    catch;
    chk("second addr", seen.addr, 32'h102);
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    stall = 1'b0;
    slow = 1'b0;
    miscompares = 0;
    n_compared = 0;
    cfg = '0;
    cfg.base = 32'h100;
    cfg.width = 12'd10;
    cfg.height = 12'd6;
    repeat (12) @(posedge core_clk);
    chk("reset valid", rsp_valid, 0);
    chk("reset ready", req_ready, 0);
    rst_n <= 1'b1;
    t_wide;
    slow <= 1'b1;
    t_sub;
    slow <= 1'b0;
    t_stall;
    conclude;
  end

  // watchdog against a hang
  initial begin
    #200000;
    miscompares++;
    conclude;
  end
endmodule
